// >>> verilog/angle_sensor_out.sv
// Sensor end: power-up shadow load, duty-cycle output and quadrature encoder
`timescale 1ns/1ps
`default_nettype none
module angle_sensor_out
  import angle_out_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic [ANGLE_W-1:0] angle_word,
  input  wire logic               angle_update,
  input  wire logic [ANGLE_W-1:0] nvm_zero_offset,
  input  wire logic [3:0]         nvm_carrier_rate_index,
  input  wire logic [2:0]         nvm_carrier_band,
  input  wire logic [3:0]         nvm_resolution,
  input  wire logic               wadr_load,
  input  wire logic [WADR_W-1:0]  wadr_value,
  output logic [WADR_W-1:0]       write_adr,
  output logic                    ready,
  angle_link_if.sensor            link
);

  typedef struct packed {
    pu_state_t          pu;
    logic [ANGLE_W-1:0] zero_off;
    logic [3:0]         rate;
    logic [2:0]         band;
    logic [3:0]         res;
    logic [WADR_W-1:0]  wadr;
    logic [ANGLE_W-1:0] rel;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   period;
    logic [CNT_W-1:0]   high_len;
    logic               pwm_low;
    logic [QPOS_W-1:0]  qpos;
    logic               a;
    logic               b;
    logic               idx;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [6:0]        sel;
    logic [29:0]       prod;
    logic [3:0]        shift;
    logic [QPOS_W-1:0] mask;
    logic [QPOS_W-1:0] target;
    logic [QPOS_W-1:0] diff;
    logic [QPOS_W-1:0] qn;
    logic [CNT_W-1:0]  cnt_inc;
    sel     = '0;
    prod    = '0;
    shift   = '0;
    mask    = '0;
    target  = '0;
    diff    = '0;
    qn      = '0;
    cnt_inc = '0;
    state_next = state_reg;

    case (state_reg.pu)
      PU_LOAD:
      begin
        state_next.zero_off = nvm_zero_offset;
        state_next.rate     = nvm_carrier_rate_index;
        state_next.band     = nvm_carrier_band;
        // Factory-only and unused codes clamp to the nearest legal one
        if (nvm_resolution < RES_MIN)
          state_next.res = RES_MIN;
        else if (nvm_resolution > RES_MAX)
          state_next.res = RES_MAX;
        else
          state_next.res = nvm_resolution;
        state_next.period = CNT_W'(1);
        state_next.cnt    = '0;
        state_next.pu     = PU_RUN;
      end
      PU_RUN:
      begin
        if (wadr_load)
          state_next.wadr = wadr_value;

        if (angle_update)
          state_next.rel = angle_word - state_reg.zero_off;

        // Duty-cycle carrier
        cnt_inc = state_reg.cnt + CNT_W'(1);
        if (cnt_inc >= state_reg.period)
        begin
          sel  = {state_reg.band, state_reg.rate};
          prod = SPAN_TAB[sel] * state_reg.rel[ANGLE_W-1 -: PWM_ANG_W];
          state_next.period   = PERIOD_TAB[sel];
          state_next.high_len = LEAD_TAB[sel] + CNT_W'(prod >> PWM_ANG_W);
          state_next.cnt      = '0;
          state_next.pwm_low  = 1'b0;
        end
        else
        begin
          state_next.cnt     = cnt_inc;
          state_next.pwm_low = (cnt_inc >= state_reg.high_len);
        end

        // Encoder: walk one state per clock toward the target
        shift  = state_reg.res - 4'h1;
        mask   = QPOS_W'((14'h0001 << (5'd15 - 5'(shift))) - 14'h0001);
        target = QPOS_W'(state_reg.rel >> shift) & mask;
        diff   = (target - state_reg.qpos) & mask;
        qn     = state_reg.qpos;
        if (diff != '0)
        begin
          // Shorter way round decides the direction
          if ((diff & (mask ^ (mask >> 1))) != '0)
            qn = (state_reg.qpos - QPOS_W'(1)) & mask;
          else
            qn = (state_reg.qpos + QPOS_W'(1)) & mask;
        end
        state_next.qpos = qn;
        // Low two bits pick the gray state, quad_state_one first
        case (qn[1:0])
          2'h0:
          begin
            state_next.a = 1'b0;
            state_next.b = 1'b0;
          end
          2'h1:
          begin
            state_next.a = 1'b0;
            state_next.b = 1'b1;
          end
          2'h2:
          begin
            state_next.a = 1'b1;
            state_next.b = 1'b1;
          end
          default:
          begin
            state_next.a = 1'b1;
            state_next.b = 1'b0;
          end
        endcase
        state_next.idx  = (qn == '0);
      end
      default:
      begin
        state_next.pu = PU_LOAD;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg          <= '0;
      state_reg.pu       <= PU_LOAD;
      state_reg.wadr     <= '0;
      state_reg.res      <= RES_RESET;
      state_reg.period   <= CNT_W'(1);
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign write_adr    = state_reg.wadr;
  assign ready        = state_reg.pu[1];
  assign link.pwm_o   = 1'b0;
  assign link.pwm_oe  = state_reg.pwm_low;
  assign link.enc_a   = state_reg.a;
  assign link.enc_b   = state_reg.b;
  assign link.enc_idx = state_reg.idx;

endmodule
`default_nettype wire

// >>> inc/angle_out_pkg.sv
// Shared constants, types and lookup tables for the angle output link
package angle_out_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ANGLE_W   = 15;
  localparam int PWM_ANG_W = 12;
  localparam int CNT_W     = 18;
  localparam int QPOS_W    = 13;
  localparam int WADR_W    = 8;

  // Duty-cycle split in percent
  localparam int LEAD_PCT = 5;
  localparam int SPAN_PCT = 90;
  localparam int PCT_FULL = 100;

  // Resolution codes: 3 gives N = 11, 14 gives N = 0
  localparam logic [3:0] RES_MIN   = 4'h3;
  localparam logic [3:0] RES_MAX   = 4'hE;
  localparam logic [3:0] RES_RESET = 4'h3;

  // ---------------------------------------------------------------
  // Carrier rates in Hz, index = band * 16 + rate index
  // ---------------------------------------------------------------
  typedef int          freq_tab_t [0:127];
  typedef logic [17:0] cnt_tab_t  [0:127];

  localparam freq_tab_t CARRIER_HZ = '{
    3125, 3101, 3077, 3053, 3030, 3008, 2985, 2963,
    2941, 2920, 2899, 2878, 2857, 2837, 2817, 2797,
    2778, 2740, 2703, 2667, 2632, 2597, 2564, 2532,
    2500, 2469, 2439, 2410, 2381, 2353, 2326, 2299,
    2273, 2222, 2174, 2128, 2083, 2041, 2000, 1961,
    1923, 1887, 1852, 1818, 1786, 1754, 1724, 1695,
    1667, 1613, 1563, 1515, 1471, 1429, 1389, 1351,
    1316, 1282, 1250, 1220, 1190, 1163, 1136, 1111,
    1087, 1042, 1000, 962, 926, 893, 862, 833,
    806, 781, 758, 735, 714, 694, 676, 658,
    641, 610, 581, 556, 532, 510, 490, 472,
    455, 439, 424, 410, 397, 385, 373, 362,
    352, 333, 316, 301, 287, 275, 263, 253,
    243, 234, 225, 217, 210, 203, 197, 191,
    185, 175, 166, 157, 150, 143, 137, 131,
    126, 121, 116, 112, 108, 105, 101, 98};

  // Period, lead and span in clock cycles, folded at elaboration
  function automatic cnt_tab_t make_tab(input int pct);
    cnt_tab_t t;
    int       p;
    for (int i = 0; i < 128; i++)
    begin
      p    = CLK_HZ / CARRIER_HZ[i];
      t[i] = CNT_W'((p * pct) / PCT_FULL);
    end
    return t;
  endfunction

  localparam cnt_tab_t PERIOD_TAB = make_tab(PCT_FULL);
  localparam cnt_tab_t LEAD_TAB   = make_tab(LEAD_PCT);
  localparam cnt_tab_t SPAN_TAB   = make_tab(SPAN_PCT);

  // ---------------------------------------------------------------
  // Receiver register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_POS    = 5'h04;
  localparam logic [4:0] REG_HIGH   = 5'h08;
  localparam logic [4:0] REG_PERIOD = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_LAGCFG = 5'h14;
  localparam logic [4:0] REG_LAG    = 5'h18;

  localparam int CTRL_CLR_BIT  = 8;
  localparam int ST_INDEX_BIT  = 0;
  localparam int ST_DIR_BIT    = 1;
  localparam int ST_SKIP_BIT   = 2;
  localparam int LAG_MULT      = 6;

  // Power-up sequence of the sensor end
  typedef enum logic [1:0] {
    PU_LOAD = 2'b01,
    PU_RUN  = 2'b10
  } pu_state_t;

endpackage

// >>> inc/angle_link_if.sv
// Pin-level link between the sensor end and the receiver end
`timescale 1ns/1ps
`default_nettype none
interface angle_link_if;
  logic pwm_o;
  logic pwm_oe;
  logic pwm_i;
  logic enc_a;
  logic enc_b;
  logic enc_idx;

  // Open-drain line with pull-up
  assign pwm_i = pwm_oe ? pwm_o : 1'b1;

  modport sensor   (output pwm_o, output pwm_oe, input pwm_i,
                    output enc_a, output enc_b, output enc_idx);
  modport receiver (input pwm_i, input enc_a, input enc_b, input enc_idx);
endinterface
`default_nettype wire

// >>> verilog/angle_receiver.sv
// Receiver end: quadrature decoder, duty meter and Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module angle_receiver
  import angle_out_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  angle_link_if.receiver   link
);

  typedef struct packed {
    logic [3:0]        sync1;
    logic [3:0]        sync2;
    logic [3:0]        prev;
    logic [3:0]        res;
    logic [QPOS_W-1:0] pos;
    logic [CNT_W-1:0]  pcnt;
    logic [CNT_W-1:0]  high;
    logic [CNT_W-1:0]  period;
    logic              st_index;
    logic              st_dir;
    logic              st_skip;
    logic [15:0]       rpm;
    logic [7:0]        resp_us;
    logic              waitreq;
    logic [31:0]       rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [1:0]        q_old;
    logic [1:0]        q_new;
    logic [1:0]        step;
    logic [QPOS_W-1:0] mask;
    logic              inc;
    logic              dec;
    logic              skip;
    logic              idx_rise;
    logic              clr;
    logic              req;
    q_old    = '0;
    q_new    = '0;
    step     = '0;
    mask     = '0;
    inc      = 1'b0;
    dec      = 1'b0;
    skip     = 1'b0;
    idx_rise = 1'b0;
    clr      = 1'b0;
    req      = 1'b0;
    state_next = state_reg;

    // Bits: 3 pwm, 2 a, 1 b, 0 index
    state_next.sync1 = {link.pwm_i, link.enc_a, link.enc_b, link.enc_idx};
    state_next.sync2 = state_reg.sync1;
    state_next.prev  = state_reg.sync2;

    q_old = {state_reg.prev[2], state_reg.prev[2] ^ state_reg.prev[1]};
    q_new = {state_reg.sync2[2], state_reg.sync2[2] ^ state_reg.sync2[1]};
    step  = q_new - q_old;
    inc   = (step == 2'd1);
    dec   = (step == 2'd3);
    skip  = (step == 2'd2);
    idx_rise = state_reg.sync2[0] & ~state_reg.prev[0];

    // Wrap at 4 * 2^N states per turn
    mask = QPOS_W'((14'h0001 << (5'd15 - 5'(state_reg.res - 4'h1))) - 14'h0001);

    req = (avs_read | avs_write) & state_reg.waitreq;
    clr = req & avs_write & (avs_address == REG_CTRL) & avs_writedata[CTRL_CLR_BIT];

    if (clr)
      state_next.pos = '0;
    else if (inc)
      state_next.pos = (state_reg.pos == mask) ? '0 : state_reg.pos + QPOS_W'(1);
    else if (dec)
      state_next.pos = (state_reg.pos == '0) ? mask : state_reg.pos - QPOS_W'(1);

    if (inc)
      state_next.st_dir = 1'b1;
    else if (dec)
      state_next.st_dir = 1'b0;

    // Duty meter: period at rising edge, high time at falling edge
    state_next.pcnt = state_reg.pcnt + CNT_W'(1);
    if (state_reg.sync2[3] & ~state_reg.prev[3])
    begin
      state_next.period = state_reg.pcnt;
      state_next.pcnt   = CNT_W'(1);
    end
    else if (~state_reg.sync2[3] & state_reg.prev[3])
      state_next.high = state_reg.pcnt;

    // Avalon slave: one wait cycle, then the answer
    state_next.waitreq = 1'b1;
    if (req)
    begin
      state_next.waitreq = 1'b0;
      state_next.rdata   = '0;
      if (avs_write)
      begin
        if (avs_address == REG_CTRL)
          state_next.res = (avs_writedata[3:0] < RES_MIN) ? RES_MIN :
                           (avs_writedata[3:0] > RES_MAX) ? RES_MAX : avs_writedata[3:0];
        else if (avs_address == REG_STATUS)
        begin
          if (avs_writedata[ST_INDEX_BIT])
            state_next.st_index = 1'b0;
          if (avs_writedata[ST_SKIP_BIT])
            state_next.st_skip = 1'b0;
        end
        else if (avs_address == REG_LAGCFG)
        begin
          state_next.rpm     = avs_writedata[15:0];
          state_next.resp_us = avs_writedata[23:16];
        end
      end
      else
      begin
        if (avs_address == REG_CTRL)
          state_next.rdata = {28'h0000000, state_reg.res};
        else if (avs_address == REG_POS)
          state_next.rdata = {19'h00000, state_reg.pos};
        else if (avs_address == REG_HIGH)
          state_next.rdata = {14'h0000, state_reg.high};
        else if (avs_address == REG_PERIOD)
          state_next.rdata = {14'h0000, state_reg.period};
        else if (avs_address == REG_STATUS)
          state_next.rdata = {29'h00000000, state_reg.st_skip, state_reg.st_dir,
                              state_reg.st_index};
        else if (avs_address == REG_LAGCFG)
          state_next.rdata = {8'h00, state_reg.resp_us, state_reg.rpm};
        else if (avs_address == REG_LAG)
          state_next.rdata = 32'(state_reg.rpm * state_reg.resp_us * LAG_MULT);
      end
    end

    // Events set after the clear so that a same-cycle event survives
    if (idx_rise)
      state_next.st_index = 1'b1;
    if (skip)
      state_next.st_skip = 1'b1;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg         <= '0;
      state_reg.sync1   <= 4'h8;
      state_reg.sync2   <= 4'h8;
      state_reg.prev    <= 4'h8;
      state_reg.res     <= RES_RESET;
      state_reg.waitreq <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign avs_readdata    = state_reg.rdata;
  assign avs_waitrequest = state_reg.waitreq;

endmodule
`default_nettype wire

// >>> test/angle_link_props.sv
// Pin checker for the link between the sensor end and the receiver end
`timescale 1ns/1ps
`default_nettype none
module angle_link_props
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic pwm_o,
  input wire logic pwm_oe,
  input wire logic pwm_i,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_idx
);
  // ------------------------------------------
  // Run length of the duty line
  // ------------------------------------------
  // Fastest carrier has a 400-cycle lead, and its tail is never shorter
  localparam int MIN_RUN = 400;

  logic        prev_reg;
  logic [19:0] run_reg;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_reg <= 1'b1;
      run_reg  <= 20'h00000;
    end
    else
    begin
      prev_reg <= pwm_i;
      run_reg  <= (pwm_i != prev_reg) ? 20'h00001 : run_reg + 20'h00001;
    end
  end

  // ------------------------------------------
  // Properties
  // ------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_state_one;
    !enc_a && !enc_b;
  endsequence

  sequence s_one_step_away;
    enc_a ^ enc_b;
  endsequence

  AST_GRAY_STEP: assert property (!($changed(enc_a) && $changed(enc_b)))
    else $error("encoder A and B changed in the same cycle");
  AST_IDX_IN_STATE_ONE: assert property (enc_idx |-> s_state_one)
    else $error("index high outside state one");
  AST_IDX_LEAVES_BY_ONE: assert property ($fell(enc_idx) |-> s_one_step_away)
    else $error("index dropped without a single-bit step");
  AST_IDX_FOLLOWS_STATE: assert property ($past(rst_b, 3) && $stable({enc_a, enc_b}) |-> $stable(enc_idx))
    else $error("index moved while encoder state held");
  AST_IDX_DROPS_ON_STEP: assert property ($past(enc_idx) && $changed({enc_a, enc_b}) |-> !enc_idx)
    else $error("index still high after leaving zero");
  AST_START_HIGH: assert property ($rose(rst_b) |-> pwm_i [*8])
    else $error("first carrier period did not start high");
  AST_RISE_HOLDS: assert property ($rose(pwm_i) |=> pwm_i [*8])
    else $error("duty line fell right after period start");
  AST_MIN_RUN: assert property ((pwm_i != prev_reg) |-> run_reg >= MIN_RUN)
    else $error("duty line level shorter than the lead");
  AST_DRIVE_LOW: assert property (pwm_oe |-> !pwm_o)
    else $error("open-drain output drove high");
endmodule
`default_nettype wire

// >>> test/tb_angle_pwm_quadrature_output.sv
// Bench joining the sensor end to the receiver end over the link
`timescale 1ns/1ps
`default_nettype none
module tb_angle_pwm_quadrature_output
  import angle_out_pkg::*;
;
  typedef struct {
    logic [2:0]  band;
    logic [3:0]  rate;
    logic [3:0]  res;
    logic [14:0] zero;
    logic [14:0] ang;
    logic [31:0] high;
    logic [31:0] period;
    logic [31:0] pos;
    logic [31:0] status;
  } row_t;

  // Carrier, trim and angle beside the high time, period, count and status they give
  row_t rows [0:3] = '{
    '{3'h0, 4'h0, 4'h3, 15'h0000, 15'h1234, 32'h58F, 32'h1F40, 32'h48D, 32'h3},
    '{3'h0, 4'hF, 4'hE, 15'h0000, 15'h7FFF, 32'h2128, 32'h22EA, 32'h3, 32'h1},
    '{3'h1, 4'h0, 4'h8, 15'h0200, 15'h0100, 32'h2124, 32'h2327, 32'hFE, 32'h1},
    '{3'h2, 4'h0, 4'h5, 15'h2222, 15'h2222, 32'h225, 32'h2AF6, 32'h0, 32'h1}};

  logic               ref_clk;
  logic               rst_b;
  logic [ANGLE_W-1:0] angle_word;
  logic               angle_update;
  logic [ANGLE_W-1:0] nvm_zero_offset;
  logic [3:0]         nvm_carrier_rate_index;
  logic [2:0]         nvm_carrier_band;
  logic [3:0]         nvm_resolution;
  logic               wadr_load;
  logic [WADR_W-1:0]  wadr_value;
  logic [WADR_W-1:0]  write_adr;
  logic               ready;
  logic [4:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic [31:0]        rd;
  int                 n_fail;
  int                 comparisons;

  angle_link_if angle_link_if_inst ();

  angle_sensor_out angle_sensor_out_inst (.ref_clk, .rst_b, .angle_word, .angle_update,
    .nvm_zero_offset, .nvm_carrier_rate_index, .nvm_carrier_band, .nvm_resolution,
    .wadr_load, .wadr_value, .write_adr, .ready, .link(angle_link_if_inst));

  angle_receiver angle_receiver_inst (.ref_clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .link(angle_link_if_inst));

  angle_link_props angle_link_props_inst (.ref_clk, .rst_b,
    .pwm_o(angle_link_if_inst.pwm_o), .pwm_oe(angle_link_if_inst.pwm_oe),
    .pwm_i(angle_link_if_inst.pwm_i), .enc_a(angle_link_if_inst.enc_a),
    .enc_b(angle_link_if_inst.enc_b), .enc_idx(angle_link_if_inst.enc_idx));

  // ------------------------------------------
  // Tasks
  // ------------------------------------------
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; one idle cycle after release
  task automatic av_xfer(input logic [4:0] adr, input logic wr, input logic [31:0] wd,
                         output logic [31:0] got);
    int n;
    n = 0;
    avs_address   <= adr;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
    begin
      n++;
      if (n > 50)
      begin
        n_fail++;
        results();
      end
      @(posedge ref_clk);
    end
    got = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic av_check(input logic [4:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    av_xfer(adr, 1'b0, 32'h0, got);
    check(got, exp);
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check({24'h0, write_adr}, 32'h0);
    check({31'h0, ready}, 32'h0);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check({31'h0, ready}, 32'h1);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial
  begin
    n_fail                 = 0;
    comparisons            = 0;
    rst_b                  = 1'b0;
    angle_word             = 15'h0;
    angle_update           = 1'b0;
    nvm_zero_offset        = 15'h0;
    nvm_carrier_rate_index = 4'h0;
    nvm_carrier_band       = 3'h0;
    nvm_resolution         = 4'h3;
    wadr_load              = 1'b0;
    wadr_value             = 8'h00;
    avs_address            = 5'h00;
    avs_read               = 1'b0;
    avs_write              = 1'b0;
    avs_writedata          = 32'h0;
    @(posedge ref_clk);
    foreach (rows[i])
    begin
      nvm_carrier_band       <= rows[i].band;
      nvm_carrier_rate_index <= rows[i].rate;
      nvm_resolution         <= rows[i].res;
      nvm_zero_offset        <= rows[i].zero;
      do_reset();
      av_check(REG_POS, 32'h0);
      av_xfer(REG_CTRL, 1'b1, {28'h0, rows[i].res}, rd);
      angle_word   <= rows[i].ang;
      angle_update <= 1'b1;
      @(posedge ref_clk);
      angle_update <= 1'b0;
      // Second period is the first to carry the new angle
      repeat (2 * rows[i].period) @(posedge ref_clk);
      av_check(REG_HIGH, rows[i].high);
      av_check(REG_PERIOD, rows[i].period);
      av_check(REG_POS, rows[i].pos);
      av_check(REG_STATUS, rows[i].status);
      av_xfer(REG_CTRL, 1'b1, {23'h0, 1'b1, 4'h0, rows[i].res}, rd);
      av_check(REG_POS, 32'h0);
    end
    wadr_value <= 8'hA5;
    wadr_load  <= 1'b1;
    @(posedge ref_clk);
    wadr_load  <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check({24'h0, write_adr}, 32'hA5);
    do_reset();
    av_check(REG_CTRL, 32'h3);
    av_xfer(REG_CTRL, 1'b1, 32'h0, rd);
    av_check(REG_CTRL, 32'h3);
    av_xfer(REG_CTRL, 1'b1, 32'hF, rd);
    av_check(REG_CTRL, 32'hE);
    av_check(REG_STATUS, 32'h1);
    av_xfer(REG_STATUS, 1'b1, 32'h7, rd);
    av_check(REG_STATUS, 32'h0);
    av_xfer(5'h1C, 1'b1, 32'hFFFFFFFF, rd);
    av_check(5'h1C, 32'h0);
    av_xfer(REG_LAGCFG, 1'b1, 32'h000A03E8, rd);
    av_check(REG_LAGCFG, 32'h000A03E8);
    av_check(REG_LAG, 32'hEA60);
    results();
  end
endmodule
`default_nettype wire
